// ==== hdl/ssd_core_if.sv ====
//----------------------------------------------------------------------
// Purpose: Links the core to its phase sequencer and subtractor.
// Assumes: All signals in the core clock domain.
// Notes:   The subtractor is purely combinational.
//----------------------------------------------------------------------
`timescale 1ns/100ps
interface ssd_core_if;
  import ssd_pkg::*;
  logic       run;
  ssd_q_type  q;
  logic [7:0] a;
  logic [7:0] b;
  logic       bin;
  logic [7:0] diff;
  logic [4:0] flags;
  modport seq  (input run, output q);
  modport alu  (input a, b, bin, output diff, flags);
  modport core (output run, a, b, bin, input q, diff, flags);
endinterface

// ==== hdl/ssd_decode.sv ====
//----------------------------------------------------------------------
// Purpose: Decode and execute sleep and three subtract instructions.
// Assumes: Data memory read is combinational while rd_en_o is high.
// Notes:   One instruction word per four-quarter cycle.
//----------------------------------------------------------------------
`timescale 1ns/100ps
module ssd_decode (
  // Clock and reset
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_i,
  // Program memory
  input  wire logic [15:0]                 instr_i,
  input  wire logic                        instr_valid_i,
  output logic                             fetch_o,
  // Configuration and wake sources
  input  wire logic                        ext_set_en_i,
  input  wire logic [5:0]                  bank_select_register_i,
  input  wire logic                        watchdog_wake_i,
  input  wire logic                        wake_i,
  // Data memory
  output logic [ssd_pkg::ADDR_W-1:0]       addr_o,
  output logic                             rd_en_o,
  input  wire logic [7:0]                  rd_data_i,
  output logic                             wr_en_o,
  output logic [7:0]                       wr_data_o,
  // Core state
  output logic [7:0]                       acc_o,
  output logic [4:0]                       flags_o,
  output logic [2:0][ssd_pkg::ADDR_W-1:0]  indirect_pointer_o,
  output logic                             timeout_status_flag_o,
  output logic                             powerdown_status_flag_o,
  output logic                             sleep_o,
  output logic                             watchdog_counter_clear_o
);
  import ssd_pkg::*;

  //--------------------------------------------------------------------
  // Submodules
  //--------------------------------------------------------------------
  ssd_core_if cif ();

  ssd_qseq u_seq (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .cif       (cif.seq)
  );

  ssd_sub_alu u_alu (
    .cif (cif.alu)
  );

  ssd_core_st_type st_ff;
  ssd_core_st_type nxt_st;

  logic [5:0]        lit6;
  logic [1:0]        sel;
  logic              dbit;
  logic              abit;
  logic [7:0]        freg;
  logic [7:0]        lit8;
  logic              idx_mode;
  logic [ADDR_W-1:0] opnd_addr;

  assign lit6 = st_ff.instr[5:0];
  assign sel  = st_ff.instr[7:6];
  assign dbit = st_ff.instr[9];
  assign abit = st_ff.instr[8];
  assign freg = st_ff.instr[7:0];
  assign lit8 = st_ff.instr[7:0];

  //--------------------------------------------------------------------
  // Operand addressing
  //--------------------------------------------------------------------
  // Access bank addresses above INDEX_MAX (0x60 to 0xff) map to the special register bank.
  always_comb begin
    idx_mode = ~abit & ext_set_en_i & (freg <= INDEX_MAX);
    if (abit) begin
      opnd_addr = {bank_select_register_i, freg};
    end else if (idx_mode) begin
      opnd_addr = st_ff.ptr[2] + {6'h00, freg};
    end else if (freg <= INDEX_MAX) begin
      opnd_addr = {6'h00, freg};
    end else begin
      opnd_addr = {ACCESS_HI_BNK, freg};
    end
  end

  //--------------------------------------------------------------------
  // Subtractor operands
  //--------------------------------------------------------------------
  always_comb begin
    cif.run = ~st_ff.sleep;
    if (st_ff.op == OP_SLW) begin
      cif.a   = lit8;
      cif.b   = st_ff.acc;
      cif.bin = 1'b0;
    end else begin
      cif.a   = st_ff.acc;
      cif.b   = rd_data_i;
      cif.bin = ~st_ff.flags[FLG_C];
    end
  end

  //--------------------------------------------------------------------
  // Quarter phase execution
  //--------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.sleep && (watchdog_wake_i || wake_i)) begin
      nxt_st.sleep = 1'b0;
      if (watchdog_wake_i) begin
        nxt_st.to = 1'b0;
      end
    end
    if (!st_ff.sleep) begin
      case (cif.q)
        Q1: begin
          nxt_st.instr = instr_i;
          nxt_st.op    = OP_NOP;
          if (instr_valid_i) begin
            if (instr_i == ENC_SLEEP) begin
              nxt_st.op = OP_SLEEP;
            end else if (instr_i[15:8] == ENC_PTR_SUB) begin
              nxt_st.op = OP_PTR;
            end else if (instr_i[15:10] == ENC_BORROW) begin
              nxt_st.op = OP_SWB;
            end else if (instr_i[15:8] == ENC_LIT_SUB) begin
              nxt_st.op = OP_SLW;
            end
          end
        end
        Q2: begin
          // Sleep does nothing here; literal ops use the latched word.
          if (st_ff.op == OP_SWB) begin
            nxt_st.addr  = opnd_addr;
            nxt_st.rd_en = 1'b1;
          end
        end
        Q3: begin
          nxt_st.rd_en     = 1'b0;
          nxt_st.res       = cif.diff;
          nxt_st.res_flags = cif.flags;
          nxt_st.ptr_res   = st_ff.ptr[sel] - {8'h00, lit6};
          if (st_ff.op == OP_SWB && dbit) begin
            nxt_st.wr_en   = 1'b1;
            nxt_st.wr_data = cif.diff;
          end
          if (st_ff.op == OP_SLEEP) begin
            nxt_st.wdt_clr = 1'b1;
          end
        end
        Q4: begin
          nxt_st.wr_en   = 1'b0;
          nxt_st.wdt_clr = 1'b0;
          case (st_ff.op)
            OP_SLEEP: begin
              nxt_st.sleep = 1'b1;
              nxt_st.to    = 1'b1;
              nxt_st.pd    = 1'b0;
            end
            OP_PTR: begin
              if (sel != PTR_NONE) begin
                nxt_st.ptr[sel] = st_ff.ptr_res;
              end
            end
            OP_SWB: begin
              nxt_st.flags = st_ff.res_flags;
              if (!dbit) begin
                nxt_st.acc = st_ff.res;
              end
            end
            OP_SLW: begin
              nxt_st.acc   = st_ff.res;
              nxt_st.flags = st_ff.res_flags;
            end
            default: begin
              nxt_st.op = OP_NOP;
            end
          endcase
        end
        default: begin
          nxt_st.op = OP_NOP;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_ff         <= '0;
      st_ff.op      <= OP_NOP;
      st_ff.acc     <= ACC_RST;
      st_ff.flags   <= FLAGS_RST;
      st_ff.to      <= TO_RST;
      st_ff.pd      <= PD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  assign fetch_o                  = ~st_ff.sleep & (cif.q == Q1);
  assign addr_o                   = st_ff.addr;
  assign rd_en_o                  = st_ff.rd_en;
  assign wr_en_o                  = st_ff.wr_en;
  assign wr_data_o                = st_ff.wr_data;
  assign acc_o                    = st_ff.acc;
  assign flags_o                  = st_ff.flags;
  assign indirect_pointer_o       = st_ff.ptr;
  assign timeout_status_flag_o    = st_ff.to;
  assign powerdown_status_flag_o  = st_ff.pd;
  assign sleep_o                  = st_ff.sleep;
  assign watchdog_counter_clear_o = st_ff.wdt_clr;

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  logic act4;
  assign act4 = ~st_ff.sleep & (cif.q == Q4);

  AST_SLEEP_ENTER: assert property (
    act4 && st_ff.op == OP_SLEEP |=> sleep_o && watchdog_counter_clear_o == 1'b0)
    else $error("sleep not entered after Q4");

  AST_SLEEP_FLAGS: assert property (
    act4 && st_ff.op == OP_SLEEP |=> timeout_status_flag_o && !powerdown_status_flag_o)
    else $error("sleep flags wrong");

  AST_WDT_WAKE: assert property (
    sleep_o && watchdog_wake_i |=> !timeout_status_flag_o && !sleep_o)
    else $error("watchdog wake did not clear time-out");

  AST_PTR_WRITE: assert property (
    act4 && st_ff.op == OP_PTR && sel != PTR_NONE
    |=> indirect_pointer_o[$past(sel)] == $past(st_ff.ptr[sel]) - {8'h00, $past(lit6)}
      && $stable(flags_o))
    else $error("pointer subtract result or flags wrong");

  AST_PTR_DECODE: assert property (
    fetch_o && instr_valid_i && instr_i[15:8] == ENC_PTR_SUB |=> st_ff.op == OP_PTR ##2 act4)
    else $error("pointer subtract not decoded");

  AST_SWB_PHASES: assert property (
    !st_ff.sleep && cif.q == Q2 && st_ff.op == OP_SWB
    |=> rd_en_o && !wr_en_o ##1 !rd_en_o && wr_en_o == $past(dbit))
    else $error("borrow subtract quarter activity wrong");

  AST_SWB_ACC: assert property (
    act4 && st_ff.op == OP_SWB && !dbit |=> acc_o == $past(st_ff.res) && !wr_en_o)
    else $error("borrow subtract accumulator not written");

  AST_BANK_ADDR: assert property (
    rd_en_o && abit |-> addr_o == {bank_select_register_i, freg})
    else $error("banked address wrong");

  AST_IDX_ADDR: assert property (
    rd_en_o && !abit && ext_set_en_i && freg <= 8'h5f
    |-> addr_o == st_ff.ptr[2] + {6'h00, freg})
    else $error("indexed address wrong");

  AST_SLW_RESULT: assert property (
    !st_ff.sleep && cif.q == Q3 && st_ff.op == OP_SLW
    |=> ##1 acc_o == 8'($past(lit8, 2) - $past(acc_o, 2))
      && flags_o[FLG_C] == ($past(lit8, 2) >= $past(acc_o, 2)))
    else $error("literal subtract result or carry wrong");

  AST_SLEEP_IDLE: assert property (
    sleep_o |-> !fetch_o && !rd_en_o && !wr_en_o)
    else $error("bus or fetch activity while asleep");

  AST_SLEEP_HOLD: assert property (
    sleep_o && !watchdog_wake_i && !wake_i |=> sleep_o)
    else $error("sleep left without a wake source");

  AST_Q4_ONLY: assert property (
    !act4 |=> $stable(acc_o) && $stable(flags_o) && $stable(indirect_pointer_o))
    else $error("architectural state changed outside Q4");

  AST_PTR_NONE: assert property (
    act4 && st_ff.op == OP_PTR && sel == PTR_NONE |=> $stable(indirect_pointer_o))
    else $error("pointer select 3 changed a pointer");

  AST_SWB_DATA: assert property (
    !st_ff.sleep && cif.q == Q3 && st_ff.op == OP_SWB && dbit
    |=> wr_en_o && wr_data_o == 8'($past(acc_o) - $past(rd_data_i) - {7'h00, ~$past(flags_o[FLG_C])}))
    else $error("borrow subtract write data wrong");

  AST_SLW_FLAGS: assert property (
    !st_ff.sleep && cif.q == Q3 && st_ff.op == OP_SLW
    |=> ##1 flags_o[FLG_Z] == ($past(lit8, 2) == $past(acc_o, 2)) && flags_o[FLG_N] == acc_o[7])
    else $error("literal subtract zero or negative flag wrong");

  AST_RD_Q3: assert property (
    rd_en_o |-> st_ff.op == OP_SWB && cif.q == Q3)
    else $error("register read outside Q3 of borrow subtract");

endmodule // ssd_decode

// ==== hdl/ssd_pkg.sv ====
//----------------------------------------------------------------------
// Purpose: Shared constants and types of the subtract and sleep decoder.
// Assumes: One core clock cycle per quarter phase.
// Notes:   Flag vector is {N, OV, Z, DC, C}.
//----------------------------------------------------------------------
package ssd_pkg;

  localparam int ADDR_W = 14;
  localparam int FLG_C  = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N  = 4;

  localparam logic [15:0] ENC_SLEEP     = 16'h0003;
  localparam logic [7:0]  ENC_PTR_SUB   = 8'he9;
  localparam logic [5:0]  ENC_BORROW    = 6'h15;
  localparam logic [7:0]  ENC_LIT_SUB   = 8'h08;
  localparam logic [7:0]  INDEX_MAX     = 8'h5f;
  localparam logic [5:0]  ACCESS_HI_BNK = 6'h3f;
  localparam logic [1:0]  PTR_NONE      = 2'h3;

  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [4:0]  FLAGS_RST = 5'h00;
  localparam logic        TO_RST    = 1'b1;
  localparam logic        PD_RST    = 1'b1;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } ssd_q_type;

  typedef enum logic [2:0] {
    OP_NOP   = 3'b000,
    OP_SLEEP = 3'b001,
    OP_PTR   = 3'b010,
    OP_SWB   = 3'b011,
    OP_SLW   = 3'b100
  } ssd_op_type;

  typedef struct packed {
    logic [15:0]                  instr;
    ssd_op_type                   op;
    logic [7:0]                   res;
    logic [4:0]                   res_flags;
    logic [ADDR_W-1:0]            ptr_res;
    logic [7:0]                   acc;
    logic [4:0]                   flags;
    logic [2:0][ADDR_W-1:0]       ptr;
    logic                         to;
    logic                         pd;
    logic                         sleep;
    logic [ADDR_W-1:0]            addr;
    logic                         rd_en;
    logic                         wr_en;
    logic [7:0]                   wr_data;
    logic                         wdt_clr;
  } ssd_core_st_type;

endpackage

// ==== hdl/ssd_qseq.sv ====
//----------------------------------------------------------------------
// Purpose: Quarter phase sequencer, one quarter per core clock.
// Assumes: run low holds the phase, used while asleep.
// Notes:   Restarts at Q1 after reset.
//----------------------------------------------------------------------
`timescale 1ns/100ps
module ssd_qseq (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Core link
  ssd_core_if.seq   cif
);
  import ssd_pkg::*;

  typedef struct packed {
    ssd_q_type q;
  } ssd_seq_st_type;

  ssd_seq_st_type st_ff;
  ssd_seq_st_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (cif.run) begin
      nxt_st.q = ssd_q_type'(st_ff.q + 2'h1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_ff.q <= Q1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cif.q = st_ff.q;

endmodule // ssd_qseq

// ==== hdl/ssd_sub_alu.sv ====
//----------------------------------------------------------------------
// Purpose: 8-bit subtractor a - b - bin with status flags.
// Assumes: bin is the borrow in, the inverse of carry.
// Notes:   Carry and digit carry are active when no borrow occurs.
//----------------------------------------------------------------------
`timescale 1ns/100ps
module ssd_sub_alu (
  // Operands and results
  ssd_core_if.alu cif
);
  import ssd_pkg::*;

  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    full = {1'b0, cif.a} - {1'b0, cif.b} - {8'h00, cif.bin};
    low  = {1'b0, cif.a[3:0]} - {1'b0, cif.b[3:0]} - {4'h0, cif.bin};
    cif.diff          = full[7:0];
    cif.flags         = 5'h00;
    cif.flags[FLG_C]  = ~full[8];
    cif.flags[FLG_DC] = ~low[4];
    cif.flags[FLG_Z]  = (full[7:0] == 8'h00);
    cif.flags[FLG_N]  = full[7];
    cif.flags[FLG_OV] = (cif.a[7] ^ cif.b[7]) & (cif.a[7] ^ full[7]);
  end

endmodule // ssd_sub_alu

// ==== tb/ssd_mem_model.sv ====
//----------------------------------------------------------------------
// Purpose: Data memory seen by the decoder, read combinationally.
// Assumes: The bench may preload cells directly before a read.
// Notes:   Deselected read data shows the inverse of the last read.
//----------------------------------------------------------------------
`timescale 1ns/100ps
module ssd_mem_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Decoder side
  input  wire logic [13:0] addr_i,
  input  wire logic        rd_en_i,
  output logic [7:0]       rd_data_o,
  input  wire logic        wr_en_i,
  input  wire logic [7:0]  wr_data_i
);
  logic [7:0] mem [0:16383];
  logic [7:0] last_ff = 8'h00;

  // A stale byte would hide a read taken in the wrong quarter.
  assign rd_data_o = rd_en_i ? mem[addr_i] : ~last_ff;

  always @(posedge clk_sys_i) begin
    if (rd_en_i) begin
      last_ff <= mem[addr_i];
    end
    if (wr_en_i) begin
      mem[addr_i] <= wr_data_i;
    end
  end
endmodule // ssd_mem_model

// ==== tb/test_subtract_and_sleep_decode.sv ====
//----------------------------------------------------------------------
// Purpose: Self-checking bench of the subtract and sleep decoder.
// Assumes: One instruction per four clocks, driven at falling edges.
// Notes:   A reference model of accumulator, flags and pointers.
//----------------------------------------------------------------------
`timescale 1ns/100ps
module test_subtract_and_sleep_decode;
  import ssd_pkg::*;
  logic clk_sys_i, rst_i, instr_valid_i, fetch_o, ext_set_en_i, watchdog_wake_i, wake_i;
  logic rd_en_o, wr_en_o, to_o, pd_o, sleep_o, clr_o;
  logic [15:0] instr_i;
  logic [5:0] bank_select_register;
  logic [13:0] addr_o;
  logic [7:0] rd_data_i, wr_data_o, acc_o, m_acc;
  logic [4:0] flags_o, m_flg;
  logic [2:0][13:0] ptr_o, m_ptr;
  logic m_to, m_pd;
  int errors, check_count, cyc;
  logic [7:0] ktbl [0:5] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'hff, 8'h80};

  ssd_decode i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
    .fetch_o(fetch_o), .ext_set_en_i(ext_set_en_i), .bank_select_register_i(bank_select_register),
    .watchdog_wake_i(watchdog_wake_i), .wake_i(wake_i), .addr_o(addr_o), .rd_en_o(rd_en_o),
    .rd_data_i(rd_data_i), .wr_en_o(wr_en_o), .wr_data_o(wr_data_o), .acc_o(acc_o), .flags_o(flags_o),
    .indirect_pointer_o(ptr_o), .timeout_status_flag_o(to_o), .powerdown_status_flag_o(pd_o),
    .sleep_o(sleep_o), .watchdog_counter_clear_o(clr_o));

  ssd_mem_model i_mem (.clk_sys_i(clk_sys_i), .addr_i(addr_o), .rd_en_i(rd_en_o), .rd_data_o(rd_data_i),
    .wr_en_i(wr_en_o), .wr_data_i(wr_data_o));

  initial begin
    clk_sys_i = 1'b0;
  end

  always begin
    #10 clk_sys_i = ~clk_sys_i;
  end

  //--------------------------------------------------------------------
  // Reference arithmetic
  //--------------------------------------------------------------------
  function automatic logic [12:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic bin);
    logic [8:0] r;
    logic [4:0] f;
    r = {1'b0, a} - {1'b0, b} - {8'h00, bin};
    f[FLG_C]  = ~r[8];
    f[FLG_DC] = ({1'b0, a[3:0]} >= ({1'b0, b[3:0]} + {4'h0, bin}));
    f[FLG_Z]  = (r[7:0] == 8'h00);
    f[FLG_OV] = (a[7] ^ b[7]) & (a[7] ^ r[7]);
    f[FLG_N]  = r[7];
    return {f, r[7:0]};
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  //--------------------------------------------------------------------
  // One instruction cycle, Q1 to the next Q1
  //--------------------------------------------------------------------
  task automatic run(input logic [15:0] w, input logic v);
    int n;
    logic [12:0] r;
    logic [7:0] fv;
    logic [13:0] ea;
    logic swb, slp;
    n = 0;
    while (fetch_o !== 1'b1 && n < 8) begin
      @(negedge clk_sys_i);
      n++;
    end
    ext_set_en_i = 1'($urandom);
    bank_select_register = 6'($urandom);
    swb = v && (w[15:10] == ENC_BORROW);
    slp = v && (w == ENC_SLEEP);
    fv = 8'($urandom);
    ea = w[8] ? {bank_select_register, w[7:0]} : (w[7:0] <= INDEX_MAX) ?
         (ext_set_en_i ? m_ptr[2] + 14'(w[7:0]) : {6'h00, w[7:0]}) : {ACCESS_HI_BNK, w[7:0]};
    if (swb) begin
      i_mem.mem[ea] = fv;
    end
    instr_i = w;
    instr_valid_i = v;
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    instr_i = ~w;
    @(negedge clk_sys_i);
    chk(64'(rd_en_o), 64'(swb));
    if (swb) begin
      chk(64'(addr_o), 64'(ea));
    end
    @(negedge clk_sys_i);
    chk(64'(wr_en_o), 64'(swb & w[9]));
    chk(64'(clr_o), 64'(slp));
    if (swb) begin
      r = sub8(m_acc, fv, ~m_flg[FLG_C]);
      if (w[9]) begin
        chk(64'(wr_data_o), 64'(r[7:0]));
      end else begin
        m_acc = r[7:0];
      end
      m_flg = r[12:8];
    end
    if (v && w[15:8] == ENC_LIT_SUB) begin
      r = sub8(w[7:0], m_acc, 1'b0);
      m_acc = r[7:0];
      m_flg = r[12:8];
    end
    if (v && w[15:8] == ENC_PTR_SUB && w[7:6] != PTR_NONE) begin
      m_ptr[w[7:6]] = m_ptr[w[7:6]] - 14'(w[5:0]);
    end
    if (slp) begin
      m_to = 1'b1;
      m_pd = 1'b0;
    end
    @(negedge clk_sys_i);
    chk(64'(acc_o), 64'(m_acc));
    chk(64'(flags_o), 64'(m_flg));
    chk(64'(ptr_o), 64'(m_ptr));
    chk(64'({sleep_o, to_o, pd_o, fetch_o}), 64'({slp, m_to, m_pd, ~slp}));
  endtask

  task automatic wake(input logic wd);
    repeat (5) @(negedge clk_sys_i);
    chk(64'({sleep_o, fetch_o}), 64'h2);
    watchdog_wake_i = wd;
    wake_i = ~wd;
    @(negedge clk_sys_i);
    watchdog_wake_i = 1'b0;
    wake_i = 1'b0;
    if (wd) begin
      m_to = 1'b0;
    end
    chk(64'({sleep_o, to_o, pd_o, fetch_o}), 64'({1'b0, m_to, m_pd, 1'b1}));
  endtask

  //--------------------------------------------------------------------
  // Hang guard
  //--------------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end

  initial begin
    errors = 0;
    check_count = 0;
    cyc = 0;
    rst_i = 1'b1;
    instr_i = 16'h0000;
    instr_valid_i = 1'b0;
    ext_set_en_i = 1'b0;
    bank_select_register = 6'h00;
    watchdog_wake_i = 1'b0;
    wake_i = 1'b0;
    m_acc = ACC_RST;
    m_flg = FLAGS_RST;
    m_ptr = '0;
    m_to = 1'b1;
    m_pd = 1'b1;
    void'($urandom(56859));
    repeat (6) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk(64'({acc_o, flags_o, to_o, pd_o, sleep_o}), 64'({ACC_RST, FLAGS_RST, 3'b110}));
    for (int i = 0; i < 12; i++) begin
      run({ENC_PTR_SUB, 2'(i % 4), (i < 4) ? 6'h3f : 6'($urandom)}, 1'b1);
    end
    $display("pointer subtract test done");
    for (int i = 0; i < 16; i++) begin
      run({ENC_LIT_SUB, (i < 6) ? ktbl[i] : 8'($urandom)}, 1'b1);
    end
    $display("literal subtract test done");
    for (int i = 0; i < 32; i++) begin
      run({ENC_BORROW, 2'($urandom), (i == 0) ? INDEX_MAX : (i == 1) ? 8'h60 : 8'($urandom)}, 1'b1);
    end
    $display("borrow subtract test done");
    run({ENC_LIT_SUB, 8'h55}, 1'b0);
    run(16'hffff, 1'b1);
    run({ENC_PTR_SUB, 8'hc5}, 1'b1);
    $display("no-effect test done");
    run(ENC_SLEEP, 1'b1);
    wake(1'b1);
    run(ENC_SLEEP, 1'b1);
    wake(1'b0);
    run({ENC_LIT_SUB, 8'h7f}, 1'b1);
    $display("sleep test done");
    results();
  end
endmodule // test_subtract_and_sleep_decode
